// [rtl/pce_top.sv]
// programmable checksum engine with ahb-lite register slave
//
// Behaviour
// [RL1] write transpose field bits 31:30 reorders writes
// [RL2] read transpose field bits 29:28 reorders reads
// [RL3] bit 27, bits 23:0 reserved, read zero
// [RL4] complement bit 26 inverts data reads
// [RL5] seed select bit 25: writes load seed
// [RL6] width bit 24: 0 sixteen, 1 thirty-two
// [RL7] seed write starts new running checksum
// [RL8] reseeding allowed any time, nothing else needed
// [RL9] software configures options before seeding
// [RL10] 8, 16, 32-bit contiguous data writes accepted
// [RL11] narrow mode uses low polynomial half only
// [RL12] narrow mode seeds from low halfword only
// [RL13] each data write advances stored checksum
// [RL14] wide mode full polynomial, seed, result
// [RL15] software reads final checksum from data
// [RL16] bytewise processing, two clocks per byte
// [RL17] transpose and complement only on access path
// [RL18] data read returns current intermediate checksum
// [RL19] short writes transposed zero-padded, valid bytes only
// [RL20] upper polynomial writes ignored in narrow mode
// [RL21] bus stalls until previous write processed
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module pce_top
	import pce_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic             hreadyout_o,
	output logic             hresp_o,
	output logic      [31:0] hrdata_o
);
	// ====================================================================
	// helper functions
	// reorder a word by transpose type
	function automatic logic [31:0] transpose(input logic [31:0] w, input logic [1:0] t);
		logic [31:0] r;
		r = w;
		for (int i = 0; i < 32; i++)
		begin
			unique case (t)
				TT_NONE:  r[i] = w[i];
				TT_BITS:  r[i] = w[(i & ~7) + 7 - (i & 7)];
				TT_BOTH:  r[i] = w[31 - i];
				TT_BYTES: r[i] = w[(24 - (i & ~7)) + (i & 7)];
			endcase
		end
		return r;
	endfunction

	// byte lanes touched by an access
	function automatic logic [3:0] lanes(input logic [2:0] sz, input logic [1:0] a);
		logic [3:0] m;
		m = 4'hf;
		if (sz == SIZE_BYTE)
			m = 4'h1 << a;
		else if (sz == SIZE_HALF)
			m = a[1] ? 4'hc : 4'h3;
		return m;
	endfunction

	// expand lane mask to a bit mask
	function automatic logic [31:0] bitmask(input logic [3:0] m);
		return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
	endfunction

	// ====================================================================
	// registers
	logic [31:0]   data_reg;
	logic [31:0]   poly_reg;
	logic [31:0]   ctrl_reg;
	logic          dp_wr_reg;
	logic [11:0]   dp_addr_reg;
	logic [3:0]    dp_lanes_reg;
	logic          hreadyout_reg;
	logic          hresp_reg;
	logic [31:0]   hrdata_reg;
	pce_state_type state_reg;
	logic [31:0]   word_reg;
	logic [3:0]    pend_reg;
	logic [7:0]    op_byte_reg;

	// ====================================================================
	// control fields
	wire [1:0] write_transpose_type  = ctrl_reg[WTT_HI:WTT_LO];
	wire [1:0] read_transpose_type   = ctrl_reg[RTT_HI:RTT_LO];
	wire       complement_on_read    = ctrl_reg[COMP_BIT];
	wire       seed_write_select     = ctrl_reg[SEED_BIT];
	wire       checksum_width_select = ctrl_reg[WIDTH_BIT];

	// ====================================================================
	// address phase decode
	wire        addr_take  = hsel_i & hready_i & htrans_i[1];
	// word-aligned offset; the low two bits only pick byte lanes
	wire [11:0] addr_low   = {haddr_i[ADDR_BITS-1:2], 2'h0}; // RL10
	wire        addr_data  = (addr_low == ADDR_DATA);
	wire        addr_poly  = (addr_low == ADDR_POLY);
	wire        addr_ctrl  = (addr_low == ADDR_CTRL);
	// a data write that feeds the engine holds the bus until done
	wire        take_calc  = addr_take & hwrite_i & addr_data & ~seed_write_select; // RL21

	// ====================================================================
	// data phase write decode
	wire        dp_done    = dp_wr_reg & hreadyout_reg;
	wire [31:0] wr_bmask   = bitmask(dp_lanes_reg);
	wire        wr_data    = dp_wr_reg & (dp_addr_reg == ADDR_DATA);
	wire        wr_poly    = dp_done & (dp_addr_reg == ADDR_POLY);
	wire        wr_ctrl    = dp_done & (dp_addr_reg == ADDR_CTRL);
	// zero-padded short write, then reordered as a whole word
	wire [31:0] wr_padded  = hwdata_i & wr_bmask; // RL19
	wire [31:0] wr_word    = transpose(wr_padded, write_transpose_type); // RL1 RL17
	// valid lanes follow the bytes when the type reverses byte order
	wire [3:0]  wr_lanes   = write_transpose_type[1] ?
		{dp_lanes_reg[0], dp_lanes_reg[1], dp_lanes_reg[2], dp_lanes_reg[3]} :
		dp_lanes_reg; // RL19
	// seed lanes: only the low halfword in narrow mode
	wire [3:0]  seed_lanes = checksum_width_select ? wr_lanes : (wr_lanes & 4'h3); // RL12 RL14
	wire [31:0] seed_bmask = bitmask(seed_lanes);
	wire        seed_load  = dp_done & (dp_addr_reg == ADDR_DATA) & seed_write_select; // RL5
	wire        calc_start = wr_data & ~hreadyout_reg & (state_reg == ST_IDLE);
	// upper polynomial half only writable in wide mode
	wire [31:0] poly_wmask = checksum_width_select ? wr_bmask :
		(wr_bmask & 32'h0000_ffff); // RL20

	// ====================================================================
	// engine byte selection, most significant valid lane first
	wire [1:0]  next_lane  = pend_reg[3] ? 2'h3 : pend_reg[2] ? 2'h2 :
		pend_reg[1] ? 2'h1 : 2'h0;
	wire [7:0]  next_byte  = word_reg[{next_lane, 3'h0} +: 8];
	wire [3:0]  pend_left  = pend_reg & ~(4'h1 << next_lane);
	wire [31:0] crc_step;

	// one byte of update; low half only in narrow mode
	pce_byte_step #(
		.WIDTH (32)
	) u_step (
		.crc_i  (data_reg),
		.byte_i (op_byte_reg),
		.poly_i (poly_reg),
		.wide_i (checksum_width_select),
		.crc_o  (crc_step)
	); // RL11 RL14

	// ====================================================================
	// read data selection
	wire [31:0] rd_trans   = transpose(data_reg, read_transpose_type); // RL2 RL17
	wire [31:0] rd_dval    = complement_on_read ? ~rd_trans : rd_trans; // RL4 RL18
	wire [31:0] rd_ctrl    = ctrl_reg & CTRL_WMASK; // RL3
	wire [31:0] rd_value   = addr_data ? rd_dval :
		addr_poly ? poly_reg :
		addr_ctrl ? rd_ctrl : 32'h0000_0000;

	// ====================================================================
	// bus address phase capture
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			dp_wr_reg    <= 1'b0;
			dp_addr_reg  <= 12'h000;
			dp_lanes_reg <= 4'h0;
		end
		else if (hreadyout_reg)
		begin
			dp_wr_reg    <= addr_take & hwrite_i;
			dp_addr_reg  <= addr_low;
			dp_lanes_reg <= lanes(hsize_i, haddr_i[1:0]); // RL10
		end
	end

	// ====================================================================
	// bus answer: ready, response and read data
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			hreadyout_reg <= 1'b1;
			hresp_reg     <= 1'b0;
			hrdata_reg    <= 32'h0000_0000;
		end
		else
		begin
			hresp_reg <= 1'b0;
			if (hreadyout_reg & take_calc)
				hreadyout_reg <= 1'b0; // RL21
			else if (state_reg == ST_UPDATE && pend_reg == 4'h0)
				hreadyout_reg <= 1'b1; // RL21
			if (hreadyout_reg & addr_take & ~hwrite_i)
				hrdata_reg <= rd_value; // RL18
		end
	end

	// ====================================================================
	// control and polynomial registers
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			ctrl_reg <= CTRL_RESET;
			poly_reg <= POLY_RESET;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_reg <= (ctrl_reg & ~(wr_bmask & CTRL_WMASK)) |
					(hwdata_i & wr_bmask & CTRL_WMASK); // RL3 RL6
			if (wr_poly)
				poly_reg <= (poly_reg & ~poly_wmask) | (hwdata_i & poly_wmask); // RL20
		end
	end

	// ====================================================================
	// engine state: fetch a byte, then update, two clocks per byte
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state_reg   <= ST_IDLE;
			word_reg    <= 32'h0000_0000;
			pend_reg    <= 4'h0;
			op_byte_reg <= 8'h00;
		end
		else
		begin
			unique case (state_reg)
				ST_IDLE:
				begin
					if (calc_start)
					begin
						word_reg  <= wr_word;
						pend_reg  <= wr_lanes;
						state_reg <= ST_FETCH;
					end
				end
				ST_FETCH:
				begin
					op_byte_reg <= next_byte; // RL16
					pend_reg    <= pend_left;
					state_reg   <= ST_UPDATE;
				end
				ST_UPDATE:
				begin
					state_reg <= (pend_reg == 4'h0) ? ST_IDLE : ST_FETCH; // RL16
				end
			endcase
		end
	end

	// ====================================================================
	// checksum state: seed load or per-byte update
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			data_reg <= DATA_RESET;
		else if (seed_load)
			data_reg <= (data_reg & ~seed_bmask) | (wr_word & seed_bmask); // RL7 RL8 RL12
		else if (state_reg == ST_UPDATE)
			data_reg <= crc_step; // RL13
	end

	// ====================================================================
	// outputs straight from flip-flops
	assign hreadyout_o = hreadyout_reg;
	assign hresp_o     = hresp_reg;
	assign hrdata_o    = hrdata_reg;
endmodule // pce_top
`default_nettype wire

// [inc/pce_pkg.sv]
// constants and types shared by the programmable checksum engine
package pce_pkg;
	// ====================================================================
	// register map (byte addresses)
	localparam logic [11:0] ADDR_DATA   = 12'h000;
	localparam logic [11:0] ADDR_POLY   = 12'h004;
	localparam logic [11:0] ADDR_CTRL   = 12'h008;
	localparam int          ADDR_BITS   = 12;

	// ====================================================================
	// reset values
	localparam logic [31:0] DATA_RESET  = 32'hffff_ffff;
	localparam logic [31:0] POLY_RESET  = 32'h0000_1021;
	localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;

	// ====================================================================
	// control field positions
	localparam int          WTT_HI      = 31;
	localparam int          WTT_LO      = 30;
	localparam int          RTT_HI      = 29;
	localparam int          RTT_LO      = 28;
	localparam int          COMP_BIT    = 26;
	localparam int          SEED_BIT    = 25;
	localparam int          WIDTH_BIT   = 24;
	// writable control bits; bit 27 and bits 23..0 stay zero
	localparam logic [31:0] CTRL_WMASK  = 32'hf700_0000;

	// ====================================================================
	// transpose types
	localparam logic [1:0]  TT_NONE     = 2'h0;
	localparam logic [1:0]  TT_BITS     = 2'h1;
	localparam logic [1:0]  TT_BOTH     = 2'h2;
	localparam logic [1:0]  TT_BYTES    = 2'h3;

	// ====================================================================
	// bus encodings
	localparam logic [2:0]  SIZE_BYTE   = 3'h0;
	localparam logic [2:0]  SIZE_HALF   = 3'h1;
	localparam logic [1:0]  TRANS_NSEQ  = 2'h2;
	localparam logic [1:0]  TRANS_SEQ   = 2'h3;

	// ====================================================================
	// widths and engine timing
	localparam int          POLY_HALF   = 16;
	localparam int          BYTE_CLOCKS = 2;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FETCH,
		ST_UPDATE
	} pce_state_type;
endpackage : pce_pkg

// [rtl/pce_byte_step.sv]
// one byte of checksum update, msb first, 16- or 32-bit wide
`timescale 1ns/1ps
`default_nettype none
module pce_byte_step
	import pce_pkg::*;
#(
	parameter int WIDTH = 32
)
(
	input  wire logic [WIDTH-1:0] crc_i,
	input  wire logic [7:0]       byte_i,
	input  wire logic [WIDTH-1:0] poly_i,
	input  wire logic             wide_i,
	output logic      [WIDTH-1:0] crc_o
);
	// ====================================================================
	// eight shift steps; narrow mode works on the low half only
	always_comb
	begin
		logic [WIDTH-1:0] c;
		logic             msb;
		c = crc_i;
		msb = 1'b0;
		if (wide_i)
			c[WIDTH-1 -: 8] = c[WIDTH-1 -: 8] ^ byte_i;
		else
			c[POLY_HALF-1 -: 8] = c[POLY_HALF-1 -: 8] ^ byte_i;
		for (int i = 0; i < 8; i++)
		begin
			msb = wide_i ? c[WIDTH-1] : c[POLY_HALF-1];
			c = c << 1;
			if (msb)
				c = c ^ (wide_i ? poly_i : {{(WIDTH-POLY_HALF){1'b0}}, poly_i[POLY_HALF-1:0]});
		end
		if (!wide_i)
			c[WIDTH-1:POLY_HALF] = crc_i[WIDTH-1:POLY_HALF]; // upper half untouched
		crc_o = c;
	end
endmodule // pce_byte_step
`default_nettype wire

// [sim/pce_top_chk.sv]
// bus-side assertions for the checksum engine
`timescale 1ns/1ps
`default_nettype none
module pce_top_chk
	import pce_pkg::*;
(
	input wire logic        core_clk_i,
	input wire logic        reset_n_i,
	input wire logic        hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0]  htrans_i,
	input wire logic        hwrite_i,
	input wire logic [2:0]  hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic        hready_i,
	input wire logic        hreadyout_o,
	input wire logic        hresp_o,
	input wire logic [31:0] hrdata_o
);
	// ========
	// helpers
	logic ctrl_ph_reg;
	logic seed_reg;
	// decode of taken address phases
	wire take = hsel_i & hready_i & htrans_i[1];
	wire at_data = haddr_i[11:2] == ADDR_DATA[11:2]; // any lane of the data word
	wire seed_now = ctrl_ph_reg ? hwdata_i[SEED_BIT] : seed_reg; // ctrl write just ending
	wire dwr = take & hwrite_i & at_data & !seed_now & (hsize_i == 3'h2);
	wire rd = take & !hwrite_i;
	// follow the seed-select bit through ctrl writes
	always_ff @(posedge core_clk_i or negedge reset_n_i)
		if (!reset_n_i)
		begin
			ctrl_ph_reg <= 1'b0;
			seed_reg <= 1'b0;
		end
		else if (hready_i)
		begin
			ctrl_ph_reg <= take & hwrite_i & (haddr_i[11:0] == ADDR_CTRL);
			seed_reg <= seed_now;
		end
	// ========
	// properties
	default clocking dc @(posedge core_clk_i);
	endclocking
	default disable iff (!reset_n_i);
	// nine wait cycles for four bytes, then ready
	sequence word_wait_s;
		!hreadyout_o [*8] ##1 !hreadyout_o ##1 hreadyout_o;
	endsequence
	word_stall_a: assert property (dwr |=> word_wait_s)
		else $error("word data write stall has wrong length");
	seed_fast_a: assert property (take && hwrite_i && at_data && seed_now |=> hreadyout_o)
		else $error("seed write was stalled");
	read_fast_a: assert property (rd |=> hreadyout_o)
		else $error("read was stalled");
	ctrl_resv_a: assert property (rd && haddr_i[11:0] == ADDR_CTRL |=> !(hrdata_o & ~CTRL_WMASK))
		else $error("reserved control bits read nonzero");
	unmapped_zero_a: assert property (rd && haddr_i[11:0] == 12'h00c |=> hrdata_o == 32'h0)
		else $error("unmapped read nonzero");
	resp_okay_a: assert property (hresp_o == 1'b0)
		else $error("response not okay");
	cfg_fast_a: assert property (take && hwrite_i && !at_data |=> hreadyout_o)
		else $error("config write was stalled");
	rdata_hold_a: assert property (!rd |=> $stable(hrdata_o))
		else $error("read data moved without a read");
endmodule // pce_top_chk
bind pce_top pce_top_chk chk (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
	.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
	.hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
	.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o));
`default_nettype wire

// [sim/pce_top_test.sv]
// self-checking bench for the checksum engine
`timescale 1ns/1ps
`default_nettype none
module pce_top_test
	import pce_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        rd_ph = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] m_data, m_poly, m_ctrl, e, c;
	logic [31:0] exp_q[$];
	wire logic        hready;
	wire logic [31:0] hrdata;
	int          mismatches = 0;
	int          n_checks = 0;
	int          seed = 32'hfeab5405;
	always #50 core_clk = ~core_clk;
	pce_top dut (.core_clk_i(core_clk), .reset_n_i(reset_n), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
		.hready_i(hready), .hreadyout_o(hready), .hresp_o(), .hrdata_o(hrdata));
	// ========
	// reference model
	function automatic logic [31:0] tp(logic [31:0] v, logic [1:0] t);
		logic [31:0] r;
		for (int i = 0; i < 32; i++)
			r[i] = v[{i[4:3], 3'h7 - i[2:0]}];
		if (t == TT_BOTH)
			r = {<<8{r}};
		if (t == TT_BYTES)
			r = {<<8{v}};
		return t == TT_NONE ? v : r;
	endfunction
	// one byte, msb first
	function automatic logic [31:0] step(logic [31:0] s, logic [7:0] b);
		if (m_ctrl[WIDTH_BIT])
			s ^= {b, 24'h0};
		else
			s[15:0] ^= {b, 8'h0};
		for (int k = 0; k < 8; k++)
			if (m_ctrl[WIDTH_BIT])
				s = {s[30:0], 1'b0} ^ (s[31] ? m_poly : 32'h0);
			else
				s[15:0] = {s[14:0], 1'b0} ^ (s[15] ? m_poly[15:0] : 16'h0);
		return s;
	endfunction
	// ========
	// bus master
	task automatic stop_test();
		if (mismatches == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic waitrdy();
		int k;
		k = 0;
		do
		begin
			@(posedge core_clk);
			k++;
		end
		while (hready !== 1'b1 && k < 100);
		if (hready !== 1'b1)
		begin
			mismatches++;
			stop_test();
		end
	endtask
	task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
		hsel <= 1'b1;
		htrans <= TRANS_NSEQ;
		haddr <= {20'h0, a};
		hwrite <= w;
		waitrdy();
		htrans <= 2'h0;
		hwdata <= d;
		waitrdy();
	endtask
	task automatic wr(logic [11:0] a, logic [31:0] d);
		logic [31:0] w;
		bus(1'b1, a, d);
		w = tp(d, m_ctrl[WTT_HI:WTT_LO]);
		case (a)
			ADDR_CTRL: m_ctrl = d & CTRL_WMASK;
			ADDR_POLY: m_poly = m_ctrl[WIDTH_BIT] ? d : {m_poly[31:16], d[15:0]};
			ADDR_DATA:
				if (m_ctrl[SEED_BIT])
					m_data = m_ctrl[WIDTH_BIT] ? w : {m_data[31:16], w[15:0]};
				else
					for (int i = 3; i >= 0; i--)
						m_data = step(m_data, w[8*i+:8]);
			default: ;
		endcase
	endtask
	task automatic rd(logic [11:0] a);
		e = tp(m_data, m_ctrl[RTT_HI:RTT_LO]) ^ {32{m_ctrl[COMP_BIT]}};
		exp_q.push_back(a == ADDR_DATA ? e : a == ADDR_POLY ? m_poly
			: a == ADDR_CTRL ? m_ctrl : 32'h0);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic do_reset();
		reset_n <= 1'b0;
		repeat (16) @(posedge core_clk);
		reset_n <= 1'b1;
		m_data = DATA_RESET;
		m_poly = POLY_RESET;
		m_ctrl = CTRL_RESET;
	endtask
	// compare each completed read with the oldest note
	always @(posedge core_clk)
	begin
		if (rd_ph && hready)
		begin
			n_checks++;
			e = exp_q.pop_front();
			if (hrdata !== e)
			begin
				mismatches++;
				$display("wrong value hrdata expected %h seen %h", e, hrdata);
			end
		end
		rd_ph <= hsel && hready && htrans[1] && !hwrite;
	end
	// ========
	// main sequence
	initial
	begin
		do_reset();
		for (int i = 0; i < 32; i++)
		begin
			if (i == 16)
				do_reset(); // mid-run reset, then wide mode
			for (int r = 0; r < 4; r++)
				rd(12'(4 * r));
			c = $random(seed) | (32'h1 << SEED_BIT);
			c[31:28] = i[3:0];
			c[WIDTH_BIT] = i[4];
			wr(ADDR_CTRL, c);
			rd(ADDR_CTRL);
			wr(ADDR_POLY, $random(seed));
			rd(ADDR_POLY);
			wr(ADDR_DATA, $random(seed));
			rd(ADDR_DATA);
			c[SEED_BIT] = 1'b0;
			wr(ADDR_CTRL, c);
			repeat (2)
			begin
				wr(ADDR_DATA, $random(seed));
				rd(ADDR_DATA);
			end
			wr(ADDR_DATA, $random(seed));
			wr(ADDR_DATA, $random(seed));
			rd(ADDR_DATA);
			wr(12'h00c, $random(seed));
		end
		repeat (3) @(posedge core_clk);
		if (exp_q.size() != 0)
			mismatches++;
		stop_test();
	end
endmodule // pce_top_test
`default_nettype wire
